/* File: rtl/ocs_clock_sync.v */
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ocs_regs.vh"
module ocs_clock_sync #(
   parameter integer NOLOCK_CYC = `OCS_NOLOCK_CYC,
   parameter integer LOCK_FRAMES = `OCS_LOCK_FRAMES,
   parameter integer SYNC_FRAMES = `OCS_SYNC_FRAMES,
   parameter integer DW = 24
) (
   input wire ref_clk, // 200 MHz clock
   input wire srst, // Synchronous reset, active high
   input wire wb_cyc_i, // Wishbone cycle
   input wire wb_stb_i, // Wishbone strobe
   input wire wb_we_i, // Wishbone write
   input wire [7:0] wb_adr_i, // Byte address
   input wire [3:0] wb_sel_i, // Byte lanes
   input wire [31:0] wb_dat_i, // Write data
   output reg [31:0] wb_dat_o, // Read data
   output reg wb_ack_o, // Acknowledge
   output wire irq, // Level interrupt
   input wire rxFrameStb, // Recovered input frame pulse
   input wire rxIsSpdif, // Decoder sees SPDIF framing
   input wire rxSlotValid, // Input slot strobe
   input wire [2:0] rxSlotIdx, // Input slot index
   input wire [DW-1:0] rxSlotData, // Input slot sample
   input wire rxCsStb, // Channel status bit strobe
   input wire rxCsBit, // Channel status bit
   input wire rxCsBlock, // Channel status block start
   output reg rxChanValid, // Channel to mixer strobe
   output reg [2:0] rxChanIdx, // Channel to mixer index
   output reg [DW-1:0] rxChanData, // Channel to mixer sample
   input wire txChanValid, // Mixer channel strobe
   input wire [2:0] txChanIdx, // Mixer channel index
   input wire [DW-1:0] txChanData, // Mixer channel sample
   output reg txSlotValid, // Output slot strobe
   output reg [2:0] txSlotIdx, // Output slot index
   output reg [DW-1:0] txSlotData, // Output slot sample
   output wire txSpdifMode, // Transmitter format select
   output wire devFrameStb, // Device sample clock pulse
   output wire clkMaster // High while running on crystal
);
   localparam [1:0] LK_NONE = 2'h0;
   localparam [1:0] LK_ACQ = 2'h1;
   localparam [1:0] LK_LOCK = 2'h2;
   localparam [15:0] NOLOCK_CNT = NOLOCK_CYC[15:0];

   function [15:0] ratePeriod;
      input [2:0] code;
      begin
         case (code)
            `OCS_R32K: ratePeriod = `OCS_P32K;
            `OCS_R44K1: ratePeriod = `OCS_P44K1;
            `OCS_R48K: ratePeriod = `OCS_P48K;
            `OCS_R88K2: ratePeriod = `OCS_P88K2;
            `OCS_R96K: ratePeriod = `OCS_P96K;
            `OCS_R176K4: ratePeriod = `OCS_P176K4;
            `OCS_R192K: ratePeriod = `OCS_P192K;
            default: ratePeriod = `OCS_P48K;
         endcase
      end
   endfunction

   function [15:0] absDiff;
      input [15:0] a;
      input [15:0] b;
      begin
         absDiff = (a > b) ? a - b : b - a;
      end
   endfunction

   // Window of about 3 % tells 44.1 from 48 and also passes varispeed
   function [2:0] classify;
      input [15:0] p;
      integer i;
      reg [15:0] nom;
      begin
         classify = `OCS_RNONE;
         nom = 16'h0000;
         for (i = 0; i < 7; i = i + 1) begin
            nom = ratePeriod(i[2:0]);
            if (absDiff(p, nom) <= {5'h00, nom[15:5]})
               classify = i[2:0];
         end
      end
   endfunction

   function [1:0] speedOf;
      input [2:0] code;
      begin
         if (code == `OCS_R176K4 || code == `OCS_R192K)
            speedOf = `OCS_SPD_QUAD;
         else if (code == `OCS_R88K2 || code == `OCS_R96K)
            speedOf = `OCS_SPD_DOUBLE;
         else
            speedOf = `OCS_SPD_SINGLE;
      end
   endfunction

   // Slot passes if below the channel count of the mode
   function slotOk;
      input [2:0] idx;
      input [1:0] spd;
      input twoCh;
      begin
         if (twoCh || spd == `OCS_SPD_QUAD)
            slotOk = (idx < 3'h2);
         else if (spd == `OCS_SPD_DOUBLE)
            slotOk = (idx < 3'h4);
         else
            slotOk = 1'b1;
      end
   endfunction

   function [31:0] byteMerge;
      input [31:0] old;
      input [31:0] wr;
      input [3:0] sel;
      integer b;
      begin
         byteMerge = old;
         for (b = 0; b < 4; b = b + 1)
            if (sel[b])
               byteMerge[b*8 +: 8] = wr[b*8 +: 8];
      end
   endfunction

   reg [31:0] ctrl_reg;
   reg [`OCS_EV_W-1:0] irqStat_reg;
   reg [`OCS_EV_W-1:0] irqMask_reg;
   reg [31:0] chStat_reg;
   reg [31:0] csShift_reg;
   reg [4:0] csCnt_reg;
   reg [1:0] lkState_reg;
   reg [15:0] rxPer_reg;
   reg [15:0] measPer_reg;
   reg [2:0] detRate_reg;
   reg [2:0] lkCnt_reg;
   reg [15:0] opPhase_reg;
   reg [15:0] lastPhase_reg;
   reg [3:0] syncCnt_reg;
   reg sync_reg;
   reg locked_prev_reg;
   reg sync_prev_reg;
   reg mism_prev_reg;
   reg [1:0] ref_prev_reg;

   wire srcOptical = ctrl_reg[`OCS_CTRL_SRC_OPT];
   wire csPass = ctrl_reg[`OCS_CTRL_CS_PASS];
   wire [2:0] cfgRate = (ctrl_reg[`OCS_CTRL_RATE_LSB +: 3] == `OCS_RNONE) ?
                        `OCS_R48K : ctrl_reg[`OCS_CTRL_RATE_LSB +: 3];
   wire locked = (lkState_reg == LK_LOCK);
   wire extActive = srcOptical && locked;
   wire [2:0] opRate = extActive ? detRate_reg : cfgRate;
   wire [1:0] opSpeed = speedOf(opRate);
   wire [15:0] cfgPer = ratePeriod(cfgRate);
   wire intWrap = (opPhase_reg >= cfgPer - 16'h0001);
   wire [1:0] activeRef = !extActive ? `OCS_REF_INT :
                          (rxIsSpdif ? `OCS_REF_SPDIF : `OCS_REF_MCH);
   wire [1:0] inStatus = !locked ? `OCS_ST_NOLOCK :
                         (sync_reg ? `OCS_ST_SYNC : `OCS_ST_LOCK);
   wire mismatch = locked && (detRate_reg != cfgRate);
   wire [15:0] opPer = extActive ? measPer_reg : cfgPer;
   wire [15:0] rxPerInc = (rxPer_reg == 16'hffff) ? rxPer_reg : rxPer_reg + 16'h0001;
   wire [2:0] rxClass = classify(rxPerInc);
   wire [15:0] phaseNow = extActive ? 16'h0000 : opPhase_reg;
   wire busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire busWr = busReq && wb_we_i;

   assign clkMaster = !extActive;
   assign devFrameStb = extActive ? rxFrameStb : intWrap;
   assign txSpdifMode = ctrl_reg[`OCS_CTRL_TX_SPDIF];
   assign irq = |(irqStat_reg & irqMask_reg);

   // Lock supervision runs in every clock mode
   always @(posedge ref_clk) begin
      if (srst) begin
         lkState_reg <= LK_NONE;
         rxPer_reg <= 16'h0000;
         measPer_reg <= 16'h0000;
         detRate_reg <= `OCS_RNONE;
         lkCnt_reg <= 3'h0;
      end else begin
         rxPer_reg <= rxFrameStb ? 16'h0000 : rxPerInc;
         if (rxFrameStb)
            measPer_reg <= rxPerInc;
         case (lkState_reg)
            LK_NONE: begin
               lkCnt_reg <= 3'h0;
               if (rxFrameStb)
                  lkState_reg <= LK_ACQ;
            end
            LK_ACQ: begin
               if (rxPer_reg >= NOLOCK_CNT) begin
                  lkState_reg <= LK_NONE;
               end else if (rxFrameStb) begin
                  if (rxClass == `OCS_RNONE || (lkCnt_reg != 3'h0 && rxClass != detRate_reg)) begin
                     lkCnt_reg <= 3'h0;
                     detRate_reg <= `OCS_RNONE;
                  end else begin
                     detRate_reg <= rxClass;
                     lkCnt_reg <= lkCnt_reg + 3'h1;
                     if (lkCnt_reg == LOCK_FRAMES[2:0] - 3'h1)
                        lkState_reg <= LK_LOCK;
                  end
               end
            end
            LK_LOCK: begin
               if (rxPer_reg >= NOLOCK_CNT ||
                   (rxFrameStb && rxClass != detRate_reg)) begin
                  lkState_reg <= LK_NONE;
                  detRate_reg <= `OCS_RNONE;
               end
            end
            default: lkState_reg <= LK_NONE;
         endcase
      end
   end

   // Internal frame divider; in slave mode it follows the input frame
   always @(posedge ref_clk) begin
      if (srst)
         opPhase_reg <= 16'h0000;
      else if (extActive ? rxFrameStb : intWrap)
         opPhase_reg <= 16'h0000;
      else
         opPhase_reg <= opPhase_reg + 16'h0001;
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         lastPhase_reg <= 16'h0000;
         syncCnt_reg <= 4'h0;
         sync_reg <= 1'b0;
      end else if (!locked || detRate_reg != opRate) begin
         syncCnt_reg <= 4'h0;
         sync_reg <= 1'b0;
      end else if (rxFrameStb) begin
         lastPhase_reg <= phaseNow;
         if (absDiff(phaseNow, lastPhase_reg) > `OCS_SYNC_TOL) begin
            syncCnt_reg <= 4'h0;
            sync_reg <= 1'b0;
         end else if (syncCnt_reg == SYNC_FRAMES[3:0] - 4'h1) begin
            sync_reg <= 1'b1;
         end else begin
            syncCnt_reg <= syncCnt_reg + 4'h1;
         end
      end
   end

   // Channel mapping in both directions
   always @(posedge ref_clk) begin
      if (srst) begin
         rxChanValid <= 1'b0;
         rxChanIdx <= 3'h0;
         rxChanData <= {DW{1'b0}};
         txSlotValid <= 1'b0;
         txSlotIdx <= 3'h0;
         txSlotData <= {DW{1'b0}};
      end else begin
         rxChanValid <= rxSlotValid && locked && slotOk(rxSlotIdx, opSpeed, rxIsSpdif);
         if (rxSlotValid) begin
            rxChanIdx <= rxSlotIdx;
            rxChanData <= rxSlotData;
         end
         txSlotValid <= txChanValid && slotOk(txChanIdx, opSpeed, txSpdifMode);
         if (txChanValid) begin
            txSlotIdx <= txChanIdx;
            txSlotData <= txChanData;
         end
      end
   end

   // channel status capture, bits arrive LSB first
   always @(posedge ref_clk) begin
      if (srst) begin
         csShift_reg <= 32'h0000_0000;
         csCnt_reg <= 5'h00;
         chStat_reg <= 32'h0000_0000;
      end else if (csPass && rxIsSpdif && locked && rxCsStb) begin
         if (rxCsBlock) begin
            csShift_reg <= {rxCsBit, 31'h0000_0000};
            csCnt_reg <= 5'h01;
         end else begin
            csShift_reg <= {rxCsBit, csShift_reg[31:1]};
            csCnt_reg <= csCnt_reg + 5'h01;
            if (csCnt_reg == 5'h1f)
               chStat_reg <= {rxCsBit, csShift_reg[31:1]};
         end
      end
   end

   // Bus slave, events and interrupt status
   always @(posedge ref_clk) begin
      if (srst) begin
         ctrl_reg <= `OCS_CTRL_RESET;
         irqStat_reg <= {`OCS_EV_W{1'b0}};
         irqMask_reg <= {`OCS_EV_W{1'b0}};
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         locked_prev_reg <= 1'b0;
         sync_prev_reg <= 1'b0;
         mism_prev_reg <= 1'b0;
         ref_prev_reg <= `OCS_REF_INT;
      end else begin
         wb_ack_o <= busReq;
         locked_prev_reg <= locked;
         sync_prev_reg <= sync_reg;
         mism_prev_reg <= mismatch;
         ref_prev_reg <= activeRef;
         if (busWr && wb_adr_i == `OCS_CTRL_OFS)
            ctrl_reg <= byteMerge(ctrl_reg, wb_dat_i, wb_sel_i);
         if (busWr && wb_adr_i == `OCS_IRQ_MASK_OFS && wb_sel_i[0])
            irqMask_reg <= wb_dat_i[`OCS_EV_W-1:0];
         // New events win over a same-cycle clear
         irqStat_reg <= (irqStat_reg &
            ~((busWr && wb_adr_i == `OCS_IRQ_STAT_OFS && wb_sel_i[0]) ?
              wb_dat_i[`OCS_EV_W-1:0] : {`OCS_EV_W{1'b0}})) |
            {activeRef != ref_prev_reg, mismatch && !mism_prev_reg,
             sync_reg != sync_prev_reg, !locked && locked_prev_reg,
             locked && !locked_prev_reg};
         if (busReq && !wb_we_i) begin
            if (wb_adr_i == `OCS_CTRL_OFS)
               wb_dat_o <= ctrl_reg;
            else if (wb_adr_i == `OCS_STATUS_OFS)
               wb_dat_o <= {24'h000000, opSpeed, mismatch, rxIsSpdif, activeRef, inStatus};
            else if (wb_adr_i == `OCS_RATE_OFS)
               wb_dat_o <= {measPer_reg, opPer[15:8] ^ opPer[15:8], 1'b0, opRate, 1'b0, detRate_reg};
            else if (wb_adr_i == `OCS_IRQ_STAT_OFS)
               wb_dat_o <= {27'h0000000, irqStat_reg};
            else if (wb_adr_i == `OCS_IRQ_MASK_OFS)
               wb_dat_o <= {27'h0000000, irqMask_reg};
            else if (wb_adr_i == `OCS_CHSTAT_OFS)
               wb_dat_o <= chStat_reg;
            else
               wb_dat_o <= 32'h0000_0000;
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/ocs_regs.vh */
// Overview of operation
// - Report No Lock when no known sample frequency is recognised on input.
// - Receiver passes 8 channels single, 1-4 double, 1-2 quad speed.
// - Transmitter sends 8 channels single, 1-4 double, 1-2 quad speed.
// - Output format setting selects multichannel optical or two-channel SPDIF.
// - SPDIF output takes its two channels from the first two slots.
// - Receiver detects SPDIF input and decodes it without configuration change.
// - Decoded SPDIF left/right land in the first two input slots.
// - Pass-through setting exposes incoming SPDIF channel status for analysis.
// - With optical clock source, the input is monitored continuously.
// - Valid input switches clock to recovered; active reference reported.
// - Reference failure falls back to internal clock as master.
// - Internal clock source runs from crystal as master regardless of input.
// - Input status is No Lock, Lock or Sync.
// - Report the clock reference currently driving the device.
// - Measure and report operating and detected input sample frequency.
// - Flag error when stable locked input rate differs from configured.
// - Never report Sync when input rate differs from operating rate.
// - 88.2/96 kHz is double speed, 176.4/192 kHz quad speed.
`ifndef OCS_REGS_VH
`define OCS_REGS_VH
// Register byte offsets
`define OCS_CTRL_OFS 8'h00
`define OCS_STATUS_OFS 8'h04
`define OCS_RATE_OFS 8'h08
`define OCS_IRQ_STAT_OFS 8'h0c
`define OCS_IRQ_MASK_OFS 8'h10
`define OCS_CHSTAT_OFS 8'h14
// Control fields
`define OCS_CTRL_SRC_OPT 0
`define OCS_CTRL_TX_SPDIF 1
`define OCS_CTRL_CS_PASS 2
`define OCS_CTRL_RATE_LSB 4
`define OCS_CTRL_RESET 32'h0000_0020
// Interrupt event bits
`define OCS_EV_LOCK_UP 0
`define OCS_EV_LOCK_DOWN 1
`define OCS_EV_SYNC_CHG 2
`define OCS_EV_MISMATCH 3
`define OCS_EV_REF_CHG 4
`define OCS_EV_W 5
// Rate codes
`define OCS_R32K 3'h0
`define OCS_R44K1 3'h1
`define OCS_R48K 3'h2
`define OCS_R88K2 3'h3
`define OCS_R96K 3'h4
`define OCS_R176K4 3'h5
`define OCS_R192K 3'h6
`define OCS_RNONE 3'h7
// Frame periods in 200 MHz cycles
`define OCS_P32K 16'h186a
`define OCS_P44K1 16'h11b7
`define OCS_P48K 16'h1047
`define OCS_P88K2 16'h08dc
`define OCS_P96K 16'h0823
`define OCS_P176K4 16'h046e
`define OCS_P192K 16'h0412
// Status encodings
`define OCS_ST_NOLOCK 2'h0
`define OCS_ST_LOCK 2'h1
`define OCS_ST_SYNC 2'h2
`define OCS_REF_INT 2'h0
`define OCS_REF_MCH 2'h1
`define OCS_REF_SPDIF 2'h2
`define OCS_SPD_SINGLE 2'h0
`define OCS_SPD_DOUBLE 2'h1
`define OCS_SPD_QUAD 2'h2
// Timing
`define OCS_CLK_MHZ 200
`define OCS_NOLOCK_US 40
`define OCS_NOLOCK_CYC (`OCS_NOLOCK_US * `OCS_CLK_MHZ)
`define OCS_LOCK_FRAMES 4
`define OCS_SYNC_FRAMES 8
`define OCS_SYNC_TOL 16'h0004
`endif

/* File: verif/ocs_clock_sync_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ocs_clock_sync_asserts #(
   parameter integer NOLOCK_CYC = 8000,
   parameter integer DW = 24
) (
   input wire ref_clk, // Clock
   input wire srst, // Reset
   input wire wb_cyc_i, // Cycle
   input wire wb_stb_i, // Strobe
   input wire wb_we_i, // Write
   input wire wb_ack_o, // Ack
   input wire rxFrameStb, // Input frame
   input wire rxIsSpdif, // Two-channel input
   input wire rxSlotValid, // Rx slot strobe
   input wire [2:0] rxSlotIdx, // Rx slot index
   input wire [DW-1:0] rxSlotData, // Rx slot sample
   input wire rxChanValid, // Rx channel strobe
   input wire [2:0] rxChanIdx, // Rx channel index
   input wire [DW-1:0] rxChanData, // Rx channel sample
   input wire txChanValid, // Tx channel strobe
   input wire [2:0] txChanIdx, // Tx channel index
   input wire [DW-1:0] txChanData, // Tx channel sample
   input wire txSlotValid, // Tx slot strobe
   input wire [2:0] txSlotIdx, // Tx slot index
   input wire [DW-1:0] txSlotData, // Tx slot sample
   input wire txSpdifMode, // Tx format
   input wire devFrameStb, // Device frame
   input wire clkMaster // On crystal
);
   reg [15:0] idleCnt_reg;
   // Cycles since the last input frame, saturating
   always @(posedge ref_clk) begin
      if (srst || rxFrameStb) begin
         idleCnt_reg <= 16'h0;
      end else if (idleCnt_reg != 16'hffff) begin
         idleCnt_reg <= idleCnt_reg + 16'h1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   bus_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held over one cycle");
   bus_ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   rx_chan_map_a: assert property (rxChanValid |-> $past(rxSlotValid) &&
      rxChanIdx == $past(rxSlotIdx) && rxChanData == $past(rxSlotData))
      else $error("rx channel not its slot");
   rx_spdif_slots_a: assert property (rxChanValid && $past(rxIsSpdif) |-> rxChanIdx < 3'h2)
      else $error("two-channel input beyond first pair");
   tx_chan_map_a: assert property (txSlotValid |-> $past(txChanValid) &&
      txSlotIdx == $past(txChanIdx) && txSlotData == $past(txChanData))
      else $error("tx slot not its channel");
   tx_spdif_slots_a: assert property (txSlotValid && $past(txSpdifMode) |-> txSlotIdx < 3'h2)
      else $error("two-channel output beyond first pair");
   fmt_by_write_a: assert property ($changed(txSpdifMode) |-> wb_ack_o && $past(wb_we_i))
      else $error("output format changed without write");
   ext_frame_a: assert property (!clkMaster |-> devFrameStb == rxFrameStb)
      else $error("slave frame not from input");
   fallback_a: assert property (idleCnt_reg > NOLOCK_CYC + 4 |-> clkMaster)
      else $error("no fallback to crystal");
endmodule
bind ocs_clock_sync ocs_clock_sync_asserts #(.NOLOCK_CYC(NOLOCK_CYC), .DW(DW)) i_chk (.*);
`default_nettype wire

/* File: verif/ocs_clock_sync_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ocs_regs.vh"
module ocs_clock_sync_bench;
   localparam integer NOLOCK = 7000;
   localparam [31:0] CSW = 32'h96c3_5a0f;
   reg ref_clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, run, spdif, rxSlotValid, txChanValid;
   reg [7:0] wb_adr_i;
   reg [3:0] wb_sel_i;
   reg [31:0] wb_dat_i, rd;
   reg [2:0] rxSlotIdx, txChanIdx, c;
   reg [23:0] rxSlotData, txChanData;
   reg [15:0] period, prevPer;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, irq, rxFrameStb, rxIsSpdif, rxCsStb, rxCsBit, rxCsBlock;
   wire rxChanValid, txSlotValid, txSpdifMode, devFrameStb, clkMaster;
   wire [2:0] rxChanIdx, txSlotIdx;
   wire [23:0] rxChanData, txSlotData;
   integer fail_count, total_checks, seed, k;
   integer cycles = 0;
   ocs_clock_sync #(.NOLOCK_CYC(NOLOCK)) i_dut (.*);
   ocs_partner #(.CSW(CSW)) i_far (.*);
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   function integer lim(input [2:0] r);
      lim = (r > 3'h4) ? 2 : (r > 3'h2) ? 4 : 8;
   endfunction
   function [1:0] spd(input [2:0] r);
      spd = (r > 3'h4) ? `OCS_SPD_QUAD : (r > 3'h2) ? `OCS_SPD_DOUBLE : `OCS_SPD_SINGLE;
   endfunction
   function [15:0] per(input [2:0] r);
      per = (r == `OCS_R192K) ? `OCS_P192K : (r == `OCS_R96K) ? `OCS_P96K : `OCS_P48K;
   endfunction
   task summarize;
      begin
         $display("checks %0d mismatches %0d", total_checks, fail_count);
         if (fail_count == 0 && total_checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   task check(input string n, input [31:0] e, input [31:0] g);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("BAD %0s expected %h seen %h", n, e, g);
         end
      end
   endtask
   task frames(input integer n);
      repeat (n) @(posedge ref_clk);
   endtask
   // Lock needs five frames after the first strobe at the new rate
   task start(input [15:0] p);
      begin
         prevPer = run ? ((period > p) ? period : p) : 16'h0;
         period <= p;
         run <= 1'b1;
         frames(5 * p + prevPer + 40);
      end
   endtask
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge ref_clk);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i <= w;
         wb_adr_i <= a;
         wb_dat_i <= d;
         while (wb_ack_o !== 1'b1) @(posedge ref_clk);
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
      end
   endtask
   task chkIrq(input e);
      begin
         #1;
         check("irq", e, irq);
      end
   endtask
   task chans(input integer rl, input integer tl);
      integer j;
      reg [23:0] rv, tv;
      begin
         for (j = 0; j < 8; j = j + 1) begin
            rv = $random(seed);
            tv = $random(seed);
            @(posedge ref_clk);
            rxSlotValid <= 1'b1;
            rxSlotIdx <= j[2:0];
            rxSlotData <= rv;
            txChanValid <= 1'b1;
            txChanIdx <= j[2:0];
            txChanData <= tv;
            @(posedge ref_clk);
            rxSlotValid <= 1'b0;
            txChanValid <= 1'b0;
            rxSlotData <= ~rv;
            txChanData <= ~tv;
            #1;
            check("rx valid", j < rl, rxChanValid);
            check("tx valid", j < tl, txSlotValid);
            check("rx data", rv, rxChanData);
            check("tx data", tv, txSlotData);
         end
      end
   endtask
   always @(posedge ref_clk) begin
      cycles = cycles + 1;
      if (cycles == 99000) begin
         fail_count = fail_count + 1;
         summarize;
      end
   end
   initial begin
      seed = 32'habbe;
      fail_count = 0;
      total_checks = 0;
      srst = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, run, spdif, rxSlotValid, txChanValid} = 7'h0;
      wb_adr_i = 8'h0;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      {rxSlotIdx, txChanIdx} = 6'h0;
      {rxSlotData, txChanData} = 48'h0;
      period = 16'h0;
      prevPer = 16'h0;
      frames(6);
      srst <= 1'b0;
      bus(0, `OCS_CTRL_OFS, 0);
      check("ctrl reset", `OCS_CTRL_RESET, rd);
      bus(1, `OCS_STATUS_OFS, 32'hff);
      bus(0, `OCS_STATUS_OFS, 0);
      check("status", 0, rd);
      bus(0, 8'h20, 0);
      check("unmapped", 0, rd);
      bus(1, `OCS_CTRL_OFS, 32'h21);
      for (k = 0; k < 3; k = k + 1) begin
         c = (k == 0) ? `OCS_R96K : (k == 1) ? `OCS_R192K : `OCS_R48K;
         start(per(c));
         bus(0, `OCS_STATUS_OFS, 0);
         check("input state", `OCS_ST_LOCK, rd[1:0]);
         check("reference", `OCS_REF_MCH, rd[3:2]);
         check("mismatch", c != `OCS_R48K, rd[5]);
         check("speed", spd(c), rd[7:6]);
         check("master", 0, clkMaster);
         bus(0, `OCS_RATE_OFS, 0);
         check("rates", {per(c), 9'h0, c, 1'b0, c}, rd);
         bus(1, `OCS_IRQ_MASK_OFS, 32'h0);
         chkIrq(0);
         bus(1, `OCS_IRQ_MASK_OFS, 32'h1);
         chkIrq(1);
         bus(1, `OCS_IRQ_STAT_OFS, 32'h1f);
         chkIrq(0);
         chans(lim(c), lim(c));
         if (c == `OCS_R192K) begin
            frames(9 * per(c));
            bus(0, `OCS_STATUS_OFS, 0);
            check("sync", `OCS_ST_SYNC, rd[1:0]);
         end
      end
      run <= 1'b0;
      frames(NOLOCK + 4200);
      bus(0, `OCS_STATUS_OFS, 0);
      check("no lock", 4'h0, rd[3:0]);
      check("master", 1, clkMaster);
      bus(1, `OCS_CTRL_OFS, 32'h20);
      start(`OCS_P192K);
      bus(0, `OCS_STATUS_OFS, 0);
      check("input state", `OCS_ST_LOCK, rd[1:0]);
      check("reference", `OCS_REF_INT, rd[3:2]);
      check("mismatch", 1, rd[5]);
      check("master", 1, clkMaster);
      bus(1, `OCS_CTRL_OFS, 32'h60);
      frames(10 * `OCS_P192K);
      bus(0, `OCS_STATUS_OFS, 0);
      check("sync", {2'h0, `OCS_REF_INT, `OCS_ST_SYNC}, rd[5:0]);
      spdif <= 1'b1;
      bus(1, `OCS_CTRL_OFS, 32'h27);
      start(`OCS_P96K);
      check("tx format", 1, txSpdifMode);
      bus(0, `OCS_STATUS_OFS, 0);
      check("reference", `OCS_REF_SPDIF, rd[3:2]);
      check("spdif seen", 1, rd[4]);
      chans(2, 2);
      frames(600);
      bus(0, `OCS_CHSTAT_OFS, 0);
      check("chan status", CSW, rd);
      summarize;
   end
endmodule
`default_nettype wire

/* File: verif/ocs_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module ocs_partner #(
   parameter [31:0] CSW = 32'h96c3_5a0f
) (
   input wire logic ref_clk, // Clock
   input wire logic run, // Frames flowing
   input wire logic [15:0] period, // Frame period in cycles
   input wire logic spdif, // Send two-channel format
   output logic rxFrameStb, // Frame pulse
   output logic rxIsSpdif, // Two-channel framing
   output logic rxCsStb, // Status bit strobe
   output logic rxCsBit, // Status bit
   output logic rxCsBlock // First bit of word
);
   logic [15:0] cnt = 16'h0;
   logic [7:0] csCnt = 8'h0;
   always @(posedge ref_clk) begin
      if (!run || rxFrameStb) begin
         cnt <= 16'h0;
      end else begin
         cnt <= cnt + 16'h1;
      end
      csCnt <= csCnt + 8'h1;
   end
   assign rxFrameStb = run && (cnt >= period - 16'h1);
   assign rxIsSpdif = spdif && run;
   assign rxCsStb = rxIsSpdif && (csCnt[2:0] == 3'h0);
   assign rxCsBlock = rxCsStb && (csCnt[7:3] == 5'h0);
   // Toggles between strobes so a stale bit is never seen
   assign rxCsBit = rxCsStb ? CSW[csCnt[7:3]] : csCnt[0];
endmodule
`default_nettype wire
